// ### logic/tbase_pkg.sv
// Package for the time base, watchdog, buzzer and carrier control block.
// Assumes an APB slave with 32-bit data and 8-bit registers in low bits.
package tbase_pkg;

  // ==========================================================
  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_CLOCK_CARRIER = 8'h00;
  localparam logic [7:0] OFS_IRQ_WATCHDOG  = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_CTRL   = 8'h08;

  // ==========================================================
  // First control register fields
  localparam int TB_SRC_BIT    = 7;
  localparam int LCD_SEL_BIT   = 5;
  localparam int DUTY_BIT      = 4;
  localparam int DIV_LSB       = 0;
  // Second control register fields
  localparam int FLAG_BIT      = 7;
  localparam int IRQ_EN_BIT    = 6;
  localparam int RATE_LSB      = 4;
  localparam int FLAG_CLR_BIT  = 3;
  localparam int WD_EN_BIT     = 1;
  localparam int WD_KICK_BIT   = 0;
  // Third control register fields
  localparam int CAR_ON_BIT    = 6;
  localparam int CAR_IDLE_BIT  = 5;
  localparam int CAR_PE_BIT    = 4;
  localparam int BZ_RATE_BIT   = 3;
  localparam int BZ_ON_BIT     = 2;
  localparam int BZ_IDLE_BIT   = 1;
  localparam int BZ_PE_BIT     = 0;

  // ==========================================================
  // Reset values
  localparam logic [1:0] RATE_RESET    = 2'h3;
  localparam logic [4:0] CARRIER_RESET = 5'h00;

  // ==========================================================
  // Divider taps (bit index n means divide by 2^(n+1))
  localparam int TAP_DIV128   = 6;
  localparam int TAP_DIV4096  = 11;
  localparam int TAP_DIV8192  = 12;
  localparam int TAP_DIV16384 = 13;
  localparam int TAP_BZ_MAIN0 = 9;   // main / 2^10
  localparam int TAP_BZ_MAIN1 = 10;  // main / 2^11
  localparam int TAP_BZ_LOW0  = 2;   // low-speed / 2^3
  localparam int TAP_BZ_LOW1  = 3;   // low-speed / 2^4
  localparam int TAP_LCD_LOW0 = 5;   // low-speed / 64
  localparam int TAP_LCD_LOW1 = 6;   // low-speed / 128
  localparam int DIV_WIDTH    = 14;
  localparam int WD_WIDTH     = 2;

  // ==========================================================
  // Grouped control fields
  typedef struct packed {
    logic       tb_src;
    logic       lcd_sel;
    logic       duty_sel;
    logic [3:0] div_sel;
  } clock_ctrl_type;

  typedef struct packed {
    logic car_on;
    logic car_idle;
    logic car_pe;
    logic bz_rate;
    logic bz_on;
    logic bz_idle;
    logic bz_pe;
  } output_ctrl_type;

  // Pin value and enable pair for open-drain or push-pull outputs
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_type;

  // Watchdog enable write-once state
  typedef enum logic [0:0] {
    WD_OPEN   = 1'b0,
    WD_LOCKED = 1'b1
  } wd_lock_type;

endpackage : tbase_pkg

// ### logic/tbase_divider.sv
// Free-running divider chain, one stage per bit, with tick detection.
// Assumes the source enables are one-cycle pulses on clk_i.
`timescale 1ns/1ps
module tbase_divider
  import tbase_pkg::*;
(
  input  wire logic                      clk_i,      // System clock
  input  wire logic                      src_tick_i, // Selected source pulse
  output logic      [tbase_pkg::DIV_WIDTH-1:0] count_o, // Divider state
  output logic      [tbase_pkg::DIV_WIDTH-1:0] rise_o   // Per-tap wrap pulse
);
  import tbase_pkg::*;

  logic [DIV_WIDTH-1:0] count = '0;  // Chain state, power-on value only
  logic [DIV_WIDTH-1:0] next_count;  // Incremented value

  // ==========================================================
  // Count on each source tick
  assign next_count = count + DIV_WIDTH'(1);
  assign count_o    = count;

  // No reset: the chain keeps its phase through reset on purpose
  always_ff @(posedge clk_i)
  begin
    if (src_tick_i)
    begin
      count <= next_count;
    end
  end

  // ==========================================================
  // Tap n wraps when bits n..0 are all ones: a ripple carry chain
  always_comb
  begin
    rise_o[0] = src_tick_i && count[0];
    for (int i = 1; i < DIV_WIDTH; i++)
    begin
      rise_o[i] = rise_o[i-1] && count[i];
    end
  end

endmodule : tbase_divider

// ### logic/tbase_pin.sv
// Output pin mux: general port, idle level or generated clock.
// Assumes the general port side supplies its own level and enable.
`timescale 1ns/1ps
module tbase_pin
  import tbase_pkg::*;
(
  input  wire logic port_enable_i, // Pin given to generator
  input  wire logic on_i,          // Generator running
  input  wire logic idle_level_i,  // Level while off
  input  wire logic wave_i,        // Generated clock
  input  wire logic gpio_out_i,    // General port level
  input  wire logic gpio_oe_i,     // General port enable
  input  wire logic open_drain_i,  // Pin drives low only
  output logic      pin_o,         // Pin output value
  output logic      pin_oe_o       // Pin output enable
);
  import tbase_pkg::*;

  logic level;  // Level the generator asks for

  // ==========================================================
  // Choose between running clock and idle level
  always_comb
  begin
    level = on_i ? wave_i : idle_level_i;
    if (!port_enable_i)
    begin
      pin_o    = gpio_out_i;
      pin_oe_o = gpio_oe_i;
    end
    else if (open_drain_i)
    begin
      // A one releases the pin; only a zero is driven
      pin_o    = 1'b0;
      pin_oe_o = !level;
    end
    else
    begin
      pin_o    = level;
      pin_oe_o = 1'b1;
    end
  end

endmodule : tbase_pin

// ### logic/time_base_tone_carrier_ctrl.sv
// Time base control: clock source, LCD clock, periodic flag, watchdog,
// buzzer tone pin and remote carrier pin, with three APB registers.
// Assumes oscillator ticks are one-cycle pulses synchronous to clk_i.
//
// Functional notes
// - Tone pin is general I/O after reset
// - Buzzer off shows buzzer idle level
// - Buzzer on outputs selected tone; reset clears
// - Tone pin is open drain
// - Buzzer rate picks divider tap per source
// - Source select: one main, zero low-speed
// - Unused register bits read as zero
// - LCD clock select picks divider tap
// - Duty bit gives third duty carrier when divider bit 3 is clear
// - Low three divider bits set carrier frequency; bit 3 only gates third duty
// - Flag set each period, cleared by software
// - Reset leaves divider chain running
// - Interrupt when flag and enable set
// - Rate field sets period; resets to ones
// - Flag clear bit is write-only strobe
// - Watchdog enable writable once after reset
// - Kick clears two-bit watchdog divider
// - Carrier on outputs carrier, else idle
// - Carrier idle level bit sets idle
// - Carrier port enable claims the pin
// - Buzzer idle level only when enabled
// - Buzzer port enable claims tone pin
// - Watchdog counts flag clock by four
// - Flag period 128/4096/8192/16384 by rate
`timescale 1ns/1ps
module time_base_tone_carrier_ctrl
  import tbase_pkg::*;
(
  input  wire logic        clk_i,          // System clock, 10 MHz
  input  wire logic        srst_i,         // Synchronous reset
  input  wire logic        main_tick_i,    // Main oscillator pulse
  input  wire logic        low_tick_i,     // Low-speed oscillator pulse
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        tone_gpio_i,    // General port level
  input  wire logic        tone_gpio_oe_i, // General port enable
  input  wire logic        car_gpio_i,     // General port level
  input  wire logic        car_gpio_oe_i,  // General port enable
  output logic             tone_pin_o,     // Tone pin value
  output logic             tone_pin_oe_o,  // Tone pin enable
  output logic             carrier_pin_o,  // Carrier pin value
  output logic             carrier_pin_oe_o, // Carrier pin enable
  output logic             lcd_clock_o,    // LCD clock tick
  output logic             timebase_irq_o, // Interrupt request
  output logic             watchdog_reset_o // Watchdog reset pulse
);
  import tbase_pkg::*;

  // ==========================================================
  // Register state
  clock_ctrl_type  clk_ctrl;       // First control register
  output_ctrl_type out_ctrl;       // Third control register
  logic            irq_flag;       // Periodic flag
  logic            irq_enable;     // Interrupt enable
  logic [1:0]      rate_sel;       // Period select
  logic            wd_enable;      // Watchdog enable
  wd_lock_type     wd_lock;        // Write-once state
  logic [WD_WIDTH-1:0] wd_count;   // Watchdog divider
  logic            wd_fire;        // Registered timeout
  logic            car_wave;       // Registered carrier level
  logic [1:0]      car_third;      // Three-phase counter for 33%

  // ==========================================================
  // Decoded signals
  logic                 src_tick;    // Selected time base tick
  logic [DIV_WIDTH-1:0] div_count;   // Divider state
  logic [DIV_WIDTH-1:0] div_rise;    // Divider wrap pulses
  logic                 period_tick; // Flag period tick
  logic                 bz_wave;     // Buzzer tone
  logic                 wr_access;   // APB write taken
  logic                 wr_clock;    // Write to first register
  logic                 wr_irq;      // Write to second register
  logic                 wr_out;      // Write to third register
  logic                 hit;         // Address is mapped
  logic                 car_step;    // Carrier stage tick

  // Ready in every access phase: zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ==========================================================
  // Address decode, shared by read and write paths
  function automatic logic is_addr(input logic [7:0] a,
                                   input logic [7:0] ofs);
    is_addr = (a == ofs);
  endfunction : is_addr

  assign hit = is_addr(paddr, OFS_CLOCK_CARRIER)
            || is_addr(paddr, OFS_IRQ_WATCHDOG)
            || is_addr(paddr, OFS_OUTPUT_CTRL);
  assign wr_access = psel && penable && pwrite;
  assign wr_clock  = wr_access && is_addr(paddr, OFS_CLOCK_CARRIER);
  assign wr_irq    = wr_access && is_addr(paddr, OFS_IRQ_WATCHDOG);
  assign wr_out    = wr_access && is_addr(paddr, OFS_OUTPUT_CTRL);

  // ==========================================================
  // Time base source and divider chain
  assign src_tick = clk_ctrl.tb_src ? main_tick_i : low_tick_i;

  tbase_divider u_divider (
    .clk_i      (clk_i),
    .src_tick_i (src_tick),
    .count_o    (div_count),
    .rise_o     (div_rise)
  );

  // Period tick per rate code, 00 fastest to 11 slowest
  always_comb
  begin
    case (rate_sel)
      2'h0:    period_tick = div_rise[TAP_DIV128];
      2'h1:    period_tick = div_rise[TAP_DIV4096];
      2'h2:    period_tick = div_rise[TAP_DIV8192];
      default: period_tick = div_rise[TAP_DIV16384];
    endcase
  end

  // ==========================================================
  // First control register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      clk_ctrl <= '{1'b0, 1'b0, CARRIER_RESET[4], CARRIER_RESET[3:0]};
    end
    else if (wr_clock)
    begin
      clk_ctrl.tb_src   <= pwdata[TB_SRC_BIT];
      clk_ctrl.lcd_sel  <= pwdata[LCD_SEL_BIT];
      clk_ctrl.duty_sel <= pwdata[DUTY_BIT];
      clk_ctrl.div_sel  <= pwdata[DIV_LSB +: 4];
    end
  end

  // ==========================================================
  // Second register: enable and rate
  always_ff @(posedge clk_i)
  begin
    if (srst_i || wd_fire)
    begin
      irq_enable <= 1'b0;
      rate_sel   <= RATE_RESET;
    end
    else if (wr_irq)
    begin
      irq_enable <= pwdata[IRQ_EN_BIT];
      rate_sel   <= pwdata[RATE_LSB +: 2];
    end
  end

  // Flag: set wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i || wd_fire)
    begin
      irq_flag <= 1'b0;
    end
    else if (period_tick)
    begin
      irq_flag <= 1'b1;
    end
    else if (wr_irq && pwdata[FLAG_CLR_BIT])
    begin
      irq_flag <= 1'b0;
    end
  end

  assign timebase_irq_o = irq_flag && irq_enable;

  // ==========================================================
  // Watchdog enable, accepted on the first write only
  always_ff @(posedge clk_i)
  begin
    if (srst_i || wd_fire)
    begin
      wd_enable <= 1'b0;
      wd_lock   <= WD_OPEN;
    end
    else if (wr_irq && wd_lock == WD_OPEN)
    begin
      wd_enable <= pwdata[WD_EN_BIT];
      wd_lock   <= WD_LOCKED;
    end
  end

  // Watchdog divider: four flag periods, kick clears it
  always_ff @(posedge clk_i)
  begin
    if (srst_i || wd_fire)
    begin
      wd_count <= '0;
      wd_fire  <= 1'b0;
    end
    else if (wr_irq && pwdata[WD_KICK_BIT])
    begin
      wd_count <= '0;
      wd_fire  <= 1'b0;
    end
    else if (period_tick)
    begin
      wd_count <= wd_count + WD_WIDTH'(1);
      wd_fire  <= wd_enable && (&wd_count);
    end
    else
    begin
      wd_fire <= 1'b0;
    end
  end

  // One-cycle pulse; the system resets through its power-on vector
  assign watchdog_reset_o = wd_fire;

  // ==========================================================
  // Third control register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      out_ctrl <= '0;
    end
    else if (wr_out)
    begin
      out_ctrl.car_on   <= pwdata[CAR_ON_BIT];
      out_ctrl.car_idle <= pwdata[CAR_IDLE_BIT];
      out_ctrl.car_pe   <= pwdata[CAR_PE_BIT];
      out_ctrl.bz_rate  <= pwdata[BZ_RATE_BIT];
      out_ctrl.bz_on    <= pwdata[BZ_ON_BIT];
      out_ctrl.bz_idle  <= pwdata[BZ_IDLE_BIT];
      out_ctrl.bz_pe    <= pwdata[BZ_PE_BIT];
    end
  end

  // ==========================================================
  // Buzzer tone from the free-running chain
  always_comb
  begin
    if (clk_ctrl.tb_src)
      bz_wave = out_ctrl.bz_rate ? div_count[TAP_BZ_MAIN1]
                                 : div_count[TAP_BZ_MAIN0];
    else
      bz_wave = out_ctrl.bz_rate ? div_count[TAP_BZ_LOW1]
                                 : div_count[TAP_BZ_LOW0];
  end

  // LCD clock as a tick at the selected tap
  always_ff @(posedge clk_i)
  begin
    if (clk_ctrl.tb_src)
      lcd_clock_o <= clk_ctrl.lcd_sel ? div_rise[TAP_DIV16384]
                                      : div_rise[TAP_DIV8192];
    else
      lcd_clock_o <= clk_ctrl.lcd_sel ? div_rise[TAP_LCD_LOW1]
                                      : div_rise[TAP_LCD_LOW0];
  end

  // ==========================================================
  // Carrier: selected source divided by 2^(div_sel[2:0]+1) at the chain tap, then 50% or 33% shaping.
  // Simplified: rates track the chain taps, not a separate prescaler.
  // Trade-off: no extra counter, but divide-by-three rows are approximate.
  assign car_step = div_rise[clk_ctrl.div_sel[2:0]];

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      car_third <= '0;
      car_wave  <= 1'b0;
    end
    else if (car_step)
    begin
      // Three steps per cycle in 33% mode lower the rate by a third
      if (clk_ctrl.duty_sel && !clk_ctrl.div_sel[3])
      begin
        // High one step of three: 33/67 duty
        car_third <= (car_third == 2'h2) ? 2'h0 : car_third + 2'h1;
        car_wave  <= (car_third == 2'h2);
      end
      else
      begin
        car_wave <= !car_wave;  // 50/50 duty
      end
    end
  end

  // ==========================================================
  // Pins
  tbase_pin u_tone_pin (
    .port_enable_i (out_ctrl.bz_pe),
    .on_i          (out_ctrl.bz_on),
    .idle_level_i  (out_ctrl.bz_idle),
    .wave_i        (bz_wave),
    .gpio_out_i    (tone_gpio_i),
    .gpio_oe_i     (tone_gpio_oe_i),
    .open_drain_i  (1'b1),
    .pin_o         (tone_pin_o),
    .pin_oe_o      (tone_pin_oe_o)
  );

  tbase_pin u_car_pin (
    .port_enable_i (out_ctrl.car_pe),
    .on_i          (out_ctrl.car_on),
    .idle_level_i  (out_ctrl.car_idle),
    .wave_i        (car_wave),
    .gpio_out_i    (car_gpio_i),
    .gpio_oe_i     (car_gpio_oe_i),
    .open_drain_i  (1'b0),
    .pin_o         (carrier_pin_o),
    .pin_oe_o      (carrier_pin_oe_o)
  );

  // ==========================================================
  // Read data; write-only and unused bits read as zero
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (is_addr(paddr, OFS_CLOCK_CARRIER))
    begin
      prdata[TB_SRC_BIT]   = clk_ctrl.tb_src;
      prdata[LCD_SEL_BIT]  = clk_ctrl.lcd_sel;
      prdata[DUTY_BIT]     = clk_ctrl.duty_sel;
      prdata[DIV_LSB +: 4] = clk_ctrl.div_sel;
    end
    else if (is_addr(paddr, OFS_IRQ_WATCHDOG))
    begin
      prdata[FLAG_BIT]       = irq_flag;
      prdata[IRQ_EN_BIT]     = irq_enable;
      prdata[RATE_LSB +: 2]  = rate_sel;
      prdata[WD_EN_BIT]      = wd_enable;  // reads back the enable
    end
    else if (is_addr(paddr, OFS_OUTPUT_CTRL))
    begin
      prdata[6:0] = out_ctrl;
    end
  end

endmodule : time_base_tone_carrier_ctrl

// ### test/tbase_ctrl_monitor.sv
// Checker for the time base block: register readback and pin muxing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module tbase_ctrl_monitor
  import tbase_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        tone_gpio_i,
  input wire logic        tone_gpio_oe_i,
  input wire logic        car_gpio_i,
  input wire logic        car_gpio_oe_i,
  input wire logic        tone_pin_o,
  input wire logic        tone_pin_oe_o,
  input wire logic        carrier_pin_o,
  input wire logic        carrier_pin_oe_o,
  input wire logic        timebase_irq_o,
  input wire logic        watchdog_reset_o
);
  // ==========================================================
  // Shadow of the output control register
  logic [6:0] sh;  // Copy of written bits
  logic       rd;  // Read access phase
  logic       wr3; // Accepted write to output control
  assign rd  = psel && penable && !pwrite;
  assign wr3 = psel && penable && pwrite && pready
               && paddr == OFS_OUTPUT_CTRL;
  // Timeout leaves this register alone, so only reset clears it
  always_ff @(posedge clk_i)
    if (srst_i) sh <= 7'h00;
    else if (wr3) sh <= pwdata[6:0];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_RSVD0: assert property (rd && paddr == OFS_CLOCK_CARRIER
    |-> prdata[31:8] == 24'h0 && !prdata[6])
    else $error("reserved bit set in first register");
  AST_WO: assert property (rd && paddr == OFS_IRQ_WATCHDOG
    |-> prdata[3:2] == 2'h0 && !prdata[WD_KICK_BIT])
    else $error("write-only bit reads back");
  AST_RSVD2: assert property (rd && paddr == OFS_OUTPUT_CTRL
    |-> prdata[31:7] == 25'h0)
    else $error("reserved bit set in third register");
  AST_IRQ: assert property (rd && paddr == OFS_IRQ_WATCHDOG
    |-> timebase_irq_o == (prdata[FLAG_BIT] && prdata[IRQ_EN_BIT]))
    else $error("request differs from flag and enable");
  AST_TONE_GPIO: assert property (!sh[BZ_PE_BIT]
    |-> tone_pin_o == tone_gpio_i && tone_pin_oe_o == tone_gpio_oe_i)
    else $error("tone pin not general port");
  AST_TONE_IDLE: assert property (sh[BZ_PE_BIT] && !sh[BZ_ON_BIT]
    |-> tone_pin_oe_o == !sh[BZ_IDLE_BIT])
    else $error("tone idle level wrong");
  AST_TONE_OD: assert property (sh[BZ_PE_BIT] |-> !tone_pin_o)
    else $error("tone pin driven high");
  AST_CAR_GPIO: assert property (!sh[CAR_PE_BIT]
    |-> carrier_pin_o == car_gpio_i && carrier_pin_oe_o == car_gpio_oe_i)
    else $error("carrier pin not general port");
  AST_CAR_IDLE: assert property (sh[CAR_PE_BIT] && !sh[CAR_ON_BIT]
    |-> carrier_pin_oe_o && carrier_pin_o == sh[CAR_IDLE_BIT])
    else $error("carrier idle level wrong");
  AST_WD_PULSE: assert property (watchdog_reset_o
    |=> !watchdog_reset_o [*8])
    else $error("timeout pulse too long");
endmodule : tbase_ctrl_monitor

bind time_base_tone_carrier_ctrl tbase_ctrl_monitor mon (.*);

// ### test/tone_carrier_partner.sv
// Buzzer and infrared transmitter on the two shared pins.
// Assumes the tone line has a pull-up and the carrier line has none.
`timescale 1ns/1ps
module tone_carrier_partner (
  input  wire logic clk_i,            // System clock
  input  wire logic clr_i,            // Clear the counters
  input  wire logic tone_pin_o,       // Tone pin value
  input  wire logic tone_pin_oe_o,    // Tone pin enable
  input  wire logic carrier_pin_o,    // Carrier pin value
  input  wire logic carrier_pin_oe_o, // Carrier pin enable
  output logic      tone_wire_o,      // Resolved tone line
  output logic      car_wire_o,       // Resolved carrier line
  output int        tone_edges_o,     // Tone line changes
  output int        car_high_o        // Carrier high cycles
);
  logic car_last = 1'b0;  // Last carrier level
  logic tone_last = 1'b1; // Last tone level
  // Released open-drain line floats up through the pull-up
  assign tone_wire_o = tone_pin_oe_o ? tone_pin_o : 1'b1;
  // Undriven carrier line shows the inverse, never a stale value
  assign car_wire_o = carrier_pin_oe_o ? carrier_pin_o : ~car_last;
  // ==========================================================
  // Edge and duty counters
  always @(posedge clk_i)
  begin
    car_last  <= car_wire_o;
    tone_last <= tone_wire_o;
    if (clr_i)
    begin
      tone_edges_o <= 0;
      car_high_o   <= 0;
    end
    else
    begin
      tone_edges_o <= tone_edges_o + int'(tone_wire_o !== tone_last);
      car_high_o   <= car_high_o + int'(car_wire_o === 1'b1);
    end
  end
endmodule : tone_carrier_partner

// ### test/tb_top.sv
// Self-checking bench: APB register tests, flag periods, timeout, pins.
// Assumes both oscillator ticks arrive every clock cycle.
`timescale 1ns/1ps
module tb_top;
  import tbase_pkg::*;
  logic clk_i, srst_i, main_tick_i, low_tick_i, clr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic tone_gpio_i, tone_gpio_oe_i, car_gpio_i, car_gpio_oe_i, e;
  logic tone_pin_o, tone_pin_oe_o, carrier_pin_o, carrier_pin_oe_o;
  logic lcd_clock_o, timebase_irq_o, watchdog_reset_o, tw, cw;
  int err_total = 0, n_checks = 0, cyc = 0, wd_pulses = 0;
  int tone_edges, car_high, c1, c2, n, lcd_n;
  logic [31:0] rv [4] = '{32'h00, 32'h30, 32'h00, 32'h00};
  int per [4] = '{128, 4096, 8192, 16384};
  int lc [4] = '{3, 1, 0, 0};
  int win [4] = '{256, 256, 2048, 2048};
  int ed [4] = '{64, 32, 4, 2};
  int hi [2] = '{192, 128};

  time_base_tone_carrier_ctrl dut (.*);
  tone_carrier_partner far (.clk_i(clk_i), .clr_i(clr),
    .tone_pin_o(tone_pin_o), .tone_pin_oe_o(tone_pin_oe_o),
    .carrier_pin_o(carrier_pin_o), .carrier_pin_oe_o(carrier_pin_oe_o),
    .tone_wire_o(tw), .car_wire_o(cw), .tone_edges_o(tone_edges),
    .car_high_o(car_high));

  // ==========================================================
  // Clock, cycle count, general port pattern, timeout pulses
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Port inputs toggle every one, two or four cycles so pass-through slips show up
  always @(posedge clk_i)
  begin
    cyc            <= cyc + 1;
    tone_gpio_i    <= cyc[0];
    tone_gpio_oe_i <= cyc[1];
    car_gpio_i     <= cyc[2];
    car_gpio_oe_i  <= cyc[0];
    lcd_n          <= clr ? 0 : lcd_n + int'(lcd_clock_o === 1'b1);
    if (watchdog_reset_o === 1'b1) wd_pulses <= wd_pulses + 1;
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, s, x);
    end
  endtask : chk
  // Bounded wait for the request, one edge past any clear
  task automatic wait_irq(output int c);
    @(posedge clk_i);
    for (int i = 0; i < 17000 && timebase_irq_o !== 1'b1; i++)
      @(posedge clk_i);
    c = cyc;
  endtask : wait_irq
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Hang guard, well beyond the expected run
  initial
  begin
    #9000000;
    err_total++;
    close_out();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    {srst_i, main_tick_i, low_tick_i} = 3'h7;
    {psel, penable, pwrite, clr, paddr, pwdata} = 44'h0;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i));
      chk(d, rv[i]);
      chk(32'(e), 32'(i == 3));
    end
    wr(OFS_CLOCK_CARRIER, 32'hFFFF_FFFF);
    rd(OFS_CLOCK_CARRIER);
    chk(d, 32'h0000_00BF);
    wr(OFS_OUTPUT_CTRL, 32'hFFFF_FFFF);
    rd(OFS_OUTPUT_CTRL);
    chk(d, 32'h0000_007F);
    wr(OFS_CLOCK_CARRIER, 32'h0);
    $display("reset and readback test done");
    // Enable once, try to undo, keep kicking, then let it run out
    wr(OFS_IRQ_WATCHDOG, 32'h02);
    wr(OFS_IRQ_WATCHDOG, 32'h00);
    rd(OFS_IRQ_WATCHDOG);
    chk(d & 32'h7F, 32'h02);
    repeat (4)
    begin
      repeat (300) @(posedge clk_i);
      wr(OFS_IRQ_WATCHDOG, 32'h03);
    end
    chk(32'(wd_pulses), 32'h0);
    for (int i = 0; i < 800 && wd_pulses == 0; i++) @(posedge clk_i);
    chk(32'(wd_pulses), 32'h1);
    rd(OFS_IRQ_WATCHDOG);
    chk(d & 32'h7F, 32'h30);
    $display("watchdog test done");
    // Flag period for each rate code
    for (int r = 0; r < 4; r++)
    begin
      wr(OFS_IRQ_WATCHDOG, 32'h48 | 32'(r << 4));
      wait_irq(c1);
      wr(OFS_IRQ_WATCHDOG, 32'h48 | 32'(r << 4));
      wait_irq(c2);
      chk(32'(c2 - c1), 32'(per[r]));
    end
    wr(OFS_IRQ_WATCHDOG, 32'h08);
    repeat (200) @(posedge clk_i);
    wr(OFS_IRQ_WATCHDOG, 32'h00);
    rd(OFS_IRQ_WATCHDOG);
    chk(d, 32'h80);
    wr(OFS_IRQ_WATCHDOG, 32'h38);
    rd(OFS_IRQ_WATCHDOG);
    chk(d, 32'h30);
    $display("flag period test done");
    // Tone idle levels, then tone rate for each source and rate bit
    wr(OFS_OUTPUT_CTRL, 32'h01);
    @(posedge clk_i);
    chk(32'(tw), 32'h0);
    wr(OFS_OUTPUT_CTRL, 32'h03);
    @(posedge clk_i);
    chk(32'(tw), 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_CLOCK_CARRIER, (32'(k / 2) << 7) | (32'(k % 2) << 5));
      wr(OFS_OUTPUT_CTRL, 32'h05 | (32'(k % 2) << 3));
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (win[k]) @(posedge clk_i);
      n = tone_edges - ed[k];
      chk(32'(n >= -1 && n <= 1), 32'h1);
      n = lcd_n - lc[k];
      chk(32'(n >= 0 && n <= 1), 32'h1);
    end
    $display("tone test done");
    // Carrier idle levels, then duty for both duty settings
    wr(OFS_CLOCK_CARRIER, 32'h0);
    wr(OFS_OUTPUT_CTRL, 32'h10);
    @(posedge clk_i);
    chk(32'(cw), 32'h0);
    wr(OFS_OUTPUT_CTRL, 32'h30);
    @(posedge clk_i);
    chk(32'(cw), 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_CLOCK_CARRIER, 32'(k) << 4);
      wr(OFS_OUTPUT_CTRL, 32'h50);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (384) @(posedge clk_i);
      n = car_high - hi[k];
      chk(32'(n >= -8 && n <= 8), 32'h1);
    end
    $display("carrier test done");
    close_out();
  end
endmodule : tb_top
